// file: core/otd_decoder.v
// Opcode timing decoder for pops, swaps, port input, address loads and flag control.
// Summary of operation
// RQ1 - 000ss111 pops a legacy segment selector: 7 real, 21 protected clocks.
// RQ2 - Escape then 10ss1001 pops an added segment selector, same timing; the code matches 1010s001.
// RQ3 - 01011rrr pops a general register in 4 clocks.
// RQ4 - 1000011w with mod reg r/m swaps: 3 register, 5 memory clocks.
// RQ5 - 10010rrr swaps a register with the accumulator in 3 clocks.
// RQ6 - Fixed-port input: 12 real, 6 or 26 protected, 26 virtual-8086.
// RQ7 - Denied virtual-8086 port raises fault vector 13 instead.
// RQ8 - 10001101 with mod reg r/m loads effective address in 2 clocks.
// RQ9 - 11000101 loads far pointer with data segment: 7 real, 22 protected.
// RQ10 - 11000100 loads far pointer with extra segment: 7 and 22.
// RQ11 - Escape then 10110100 loads far pointer to first added segment: 7, 25.
// RQ12 - Escape then 10110101 loads far pointer to second added segment: 7, 25.
// RQ13 - Escape then 10110010 loads far pointer to stack segment: 7, 22.
// RQ14 - 11111000 clears carry in 2 clocks.
// RQ15 - 11111100 clears direction flag in 2 clocks.
// RQ16 - 11111010 clears interrupt enable in 8 clocks.
// RQ17 - Escape then 00000110 clears task-switched flag in 6 clocks.
// RQ18 - 11110101 inverts carry in 2 clocks.
// RQ19 - With two counts, register operand takes smaller, memory larger.
// RQ20 - Add 1 clock when the address combines two general registers.
// RQ21 - Low opcode bit w selects byte when zero, full width when one.
`timescale 1ns/1ps
`default_nettype none
`include "otd_consts.vh"
module otd_decoder (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Byte stream from the prefetch queue.
  input wire byte_valid,
  input wire [7:0] byte_data,
  output reg byte_ready,
  // Processor state.
  input wire [1:0] mode,
  input wire [1:0] current_privilege_level,
  input wire [1:0] io_privilege_level,
  input wire port_permitted,
  input wire addr32,
  // Decode result.
  output reg done,
  output reg [4:0] op_class,
  output reg [5:0] clocks,
  output reg [2:0] reg_sel,
  output reg [1:0] seg_sel,
  output reg wide,
  output reg mem_operand,
  output reg [7:0] port_num,
  output reg [7:0] fault_vector
);
  localparam ST_FIRST = 3'h0;
  localparam ST_ESC = 3'h1;
  localparam ST_MODRM = 3'h2;
  localparam ST_SIB = 3'h3;
  localparam ST_PORT = 3'h4;

  reg [2:0] state;
  reg [7:0] op_byte;
  reg escaped;
  reg [7:0] modrm_byte;
  reg [2:0] next_state;
  reg next_done;
  reg [4:0] next_op_class;
  reg [5:0] next_clocks;
  reg [2:0] next_reg_sel;
  reg [1:0] next_seg_sel;
  reg next_wide;
  reg next_mem;
  reg [7:0] next_port;
  reg [7:0] next_vector;

  wire take;
  wire prot;
  wire m_is_reg;
  wire [2:0] m_reg;
  wire m_two_reg;
  wire [7:0] split_modrm;
  wire [7:0] split_sib;
  wire port_fault;
  wire [5:0] port_clocks;

  assign take = byte_valid && byte_ready;
  assign prot = (mode != `OTD_MODE_REAL);
  assign split_modrm = (state == ST_MODRM) ? byte_data : modrm_byte;
  assign split_sib = (state == ST_SIB) ? byte_data : 8'h00;

  otd_modrm_split u_split (
    .modrm(split_modrm),
    .addr32(addr32),
    .sib(split_sib),
    .is_reg(m_is_reg),
    .reg_field(m_reg),
    .two_reg_ea(m_two_reg)
  );

  otd_port_check u_port (
    .mode(mode),
    .current_privilege_level(current_privilege_level),
    .io_privilege_level(io_privilege_level),
    .port_permitted(port_permitted),
    .fault(port_fault),
    .clocks(port_clocks)
  );

  // Base count of a mod reg r/m instruction, before any address penalty.
  function [5:0] modrm_clocks;
    input [7:0] op;
    input esc;
    input is_reg;
    input is_prot;
    begin
      modrm_clocks = `OTD_CLK_EA_LOAD;
      if (!esc && (op[7:1] == `OTD_SWAP_RM_VAL))
        modrm_clocks = is_reg ? `OTD_CLK_SWAP_REG : `OTD_CLK_SWAP_MEM; // RQ4 RQ19
      else if (!esc && (op == `OTD_EA_LOAD))
        modrm_clocks = `OTD_CLK_EA_LOAD; // RQ8
      else if (esc && ((op == `OTD_FPL_FSEG) || (op == `OTD_FPL_GSEG)))
        modrm_clocks = is_prot ? `OTD_CLK_FPL_XPROT : `OTD_CLK_FPL_REAL; // RQ11 RQ12
      else
        modrm_clocks = is_prot ? `OTD_CLK_FPL_PROT : `OTD_CLK_FPL_REAL; // RQ9 RQ10 RQ13
    end
  endfunction

  // Operation class of a mod reg r/m instruction.
  function [4:0] modrm_class;
    input [7:0] op;
    input esc;
    begin
      modrm_class = `OTD_OP_UNKNOWN;
      if (!esc && (op[7:1] == `OTD_SWAP_RM_VAL))
        modrm_class = `OTD_OP_SWAP_RM; // RQ4
      else if (!esc && (op == `OTD_EA_LOAD))
        modrm_class = `OTD_OP_EA_LOAD; // RQ8
      else if (!esc && (op == `OTD_FPL_DSEG))
        modrm_class = `OTD_OP_FPL_DSEG; // RQ9
      else if (!esc && (op == `OTD_FPL_ESEG))
        modrm_class = `OTD_OP_FPL_ESEG; // RQ10
      else if (esc && (op == `OTD_FPL_FSEG))
        modrm_class = `OTD_OP_FPL_FSEG; // RQ11
      else if (esc && (op == `OTD_FPL_GSEG))
        modrm_class = `OTD_OP_FPL_GSEG; // RQ12
      else if (esc && (op == `OTD_FPL_SSEG))
        modrm_class = `OTD_OP_FPL_SSEG; // RQ13
      else
        modrm_class = `OTD_OP_UNKNOWN;
    end
  endfunction

  // Finishes a mod reg r/m instruction once its address is fully known.
  task finish_modrm;
    input two_reg;
    begin
      next_state = ST_FIRST;
      next_done = 1'b1;
      next_op_class = modrm_class(op_byte, escaped);
      next_clocks = modrm_clocks(op_byte, escaped, !next_mem, prot) +
        (two_reg ? `OTD_CLK_TWO_REG_EA : 6'h00); // RQ20
    end
  endtask

  always @*
  begin
    next_state = state;
    next_done = 1'b0;
    next_op_class = op_class;
    next_clocks = clocks;
    next_reg_sel = reg_sel;
    next_seg_sel = seg_sel;
    next_wide = wide;
    next_mem = mem_operand;
    next_port = port_num;
    next_vector = fault_vector;
    if (take)
    begin
      case (state)
        ST_FIRST:
        begin
          next_reg_sel = byte_data[2:0];
          next_wide = 1'b1;
          next_mem = 1'b0;
          next_vector = 8'h00;
          next_done = 1'b1;
          if (byte_data == `OTD_ESCAPE)
          begin
            next_done = 1'b0;
            next_state = ST_ESC;
          end
          else if (((byte_data & `OTD_POP_SEG_MASK) == `OTD_POP_SEG_VAL) &&
                   (byte_data[4:3] != `OTD_POP_SEG_CS))
          begin
            next_op_class = `OTD_OP_POP_SEG; // RQ1
            next_seg_sel = byte_data[4:3];
            next_clocks = prot ? `OTD_CLK_POP_SEG_PROT : `OTD_CLK_POP_SEG_REAL; // RQ1
          end
          else if (byte_data[7:3] == `OTD_POP_REG_VAL)
          begin
            next_op_class = `OTD_OP_POP_REG; // RQ3
            next_clocks = `OTD_CLK_POP_REG; // RQ3
          end
          else if (byte_data[7:3] == `OTD_SWAP_ACC_VAL)
          begin
            next_op_class = `OTD_OP_SWAP_ACC; // RQ5
            next_clocks = `OTD_CLK_SWAP_ACC; // RQ5
          end
          else if (byte_data[7:1] == `OTD_IN_FIXED_VAL)
          begin
            next_done = 1'b0;
            next_wide = byte_data[0]; // RQ21
            next_state = ST_PORT;
          end
          else if ((byte_data[7:1] == `OTD_SWAP_RM_VAL) || (byte_data == `OTD_EA_LOAD) ||
                   (byte_data == `OTD_FPL_DSEG) || (byte_data == `OTD_FPL_ESEG))
          begin
            next_done = 1'b0;
            next_wide = (byte_data[7:1] == `OTD_SWAP_RM_VAL) ? byte_data[0] : 1'b1; // RQ21
            next_state = ST_MODRM;
          end
          else if (byte_data == `OTD_CARRY_CLEAR)
          begin
            next_op_class = `OTD_OP_CARRY_CLR; // RQ14
            next_clocks = `OTD_CLK_FLAG; // RQ14
          end
          else if (byte_data == `OTD_DIR_CLEAR)
          begin
            next_op_class = `OTD_OP_DIR_CLR; // RQ15
            next_clocks = `OTD_CLK_FLAG; // RQ15
          end
          else if (byte_data == `OTD_IRQ_CLEAR)
          begin
            next_op_class = `OTD_OP_IRQ_CLR; // RQ16
            next_clocks = `OTD_CLK_IRQ_CLR; // RQ16
          end
          else if (byte_data == `OTD_CARRY_INV)
          begin
            next_op_class = `OTD_OP_CARRY_INV; // RQ18
            next_clocks = `OTD_CLK_FLAG; // RQ18
          end
          else
          begin
            // An opcode outside the subset still ends with done and a zero count.
            next_op_class = `OTD_OP_UNKNOWN;
            next_clocks = 6'h00;
          end
        end
        ST_ESC:
        begin
          next_state = ST_FIRST;
          next_done = 1'b1;
          if ((byte_data & `OTD_POP_XSEG_MASK) == `OTD_POP_XSEG_VAL)
          begin
            next_op_class = `OTD_OP_POP_XSEG; // RQ2
            next_seg_sel = {1'b1, byte_data[3]};
            next_clocks = prot ? `OTD_CLK_POP_SEG_PROT : `OTD_CLK_POP_SEG_REAL; // RQ2
          end
          else if (byte_data == `OTD_TS_CLEAR)
          begin
            next_op_class = `OTD_OP_TS_CLR; // RQ17
            next_clocks = `OTD_CLK_TS_CLR; // RQ17
          end
          else if ((byte_data == `OTD_FPL_FSEG) || (byte_data == `OTD_FPL_GSEG) ||
                   (byte_data == `OTD_FPL_SSEG))
          begin
            next_done = 1'b0;
            next_state = ST_MODRM;
          end
          else
          begin
            // Class and count change only with done, so an unknown escape form is set here.
            next_op_class = `OTD_OP_UNKNOWN;
            next_clocks = 6'h00;
          end
        end
        ST_MODRM:
        begin
          next_reg_sel = m_reg;
          next_mem = !m_is_reg;
          // A 32-bit address with a scaled-index byte waits for that byte.
          if (addr32 && !m_is_reg && (byte_data[2:0] == 3'h4))
            next_state = ST_SIB;
          else
            finish_modrm(m_two_reg);
        end
        ST_SIB:
          finish_modrm(m_two_reg);
        ST_PORT:
        begin
          next_state = ST_FIRST;
          next_done = 1'b1;
          next_port = byte_data;
          next_clocks = port_clocks; // RQ6
          if (port_fault)
          begin
            next_op_class = `OTD_OP_GP_FAULT; // RQ7
            next_vector = `OTD_GP_VECTOR; // RQ7
          end
          else
            next_op_class = `OTD_OP_IN_FIXED; // RQ6
        end
        default:
          next_state = ST_FIRST;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_FIRST;
      op_byte <= 8'h00;
      escaped <= 1'b0;
      modrm_byte <= 8'h00;
      byte_ready <= 1'b0;
      done <= 1'b0;
      op_class <= `OTD_OP_NONE;
      clocks <= 6'h00;
      reg_sel <= 3'h0;
      seg_sel <= 2'h0;
      wide <= 1'b0;
      mem_operand <= 1'b0;
      port_num <= 8'h00;
      fault_vector <= 8'h00;
    end
    else
    begin
      byte_ready <= 1'b1;
      state <= next_state;
      done <= next_done;
      op_class <= next_op_class;
      clocks <= next_clocks;
      reg_sel <= next_reg_sel;
      seg_sel <= next_seg_sel;
      wide <= next_wide;
      mem_operand <= next_mem;
      port_num <= next_port;
      fault_vector <= next_vector;
      if (take && (state == ST_FIRST))
      begin
        op_byte <= byte_data;
        escaped <= 1'b0;
      end
      if (take && (state == ST_ESC))
      begin
        op_byte <= byte_data;
        escaped <= 1'b1;
      end
      if (take && (state == ST_MODRM))
        modrm_byte <= byte_data;
    end
  end
endmodule // otd_decoder
`default_nettype wire

// file: pkg/otd_consts.vh
// Opcode patterns, mode codes and clock counts for the opcode timing decoder.
`ifndef OTD_CONSTS_VH
`define OTD_CONSTS_VH
// Operating modes.
`define OTD_MODE_REAL 2'h0
`define OTD_MODE_PROT 2'h1
`define OTD_MODE_V86 2'h2
// Opcode bytes and masks.
`define OTD_ESCAPE 8'h0F
`define OTD_POP_SEG_MASK 8'hE7
`define OTD_POP_SEG_VAL 8'h07
`define OTD_POP_SEG_CS 2'h1
`define OTD_POP_XSEG_MASK 8'hF7
`define OTD_POP_XSEG_VAL 8'hA1
`define OTD_POP_REG_VAL 5'h0B
`define OTD_SWAP_RM_VAL 7'h43
`define OTD_SWAP_ACC_VAL 5'h12
`define OTD_IN_FIXED_VAL 7'h72
`define OTD_EA_LOAD 8'h8D
`define OTD_FPL_DSEG 8'hC5
`define OTD_FPL_ESEG 8'hC4
`define OTD_FPL_FSEG 8'hB4
`define OTD_FPL_GSEG 8'hB5
`define OTD_FPL_SSEG 8'hB2
`define OTD_CARRY_CLEAR 8'hF8
`define OTD_DIR_CLEAR 8'hFC
`define OTD_IRQ_CLEAR 8'hFA
`define OTD_TS_CLEAR 8'h06
`define OTD_CARRY_INV 8'hF5
// Mod field value that selects a register operand.
`define OTD_MOD_REG 2'h3
// Operation classes reported with each decode.
`define OTD_OP_NONE 5'h00
`define OTD_OP_POP_SEG 5'h01
`define OTD_OP_POP_XSEG 5'h02
`define OTD_OP_POP_REG 5'h03
`define OTD_OP_SWAP_RM 5'h04
`define OTD_OP_SWAP_ACC 5'h05
`define OTD_OP_IN_FIXED 5'h06
`define OTD_OP_GP_FAULT 5'h07
`define OTD_OP_EA_LOAD 5'h08
`define OTD_OP_FPL_DSEG 5'h09
`define OTD_OP_FPL_ESEG 5'h0A
`define OTD_OP_FPL_FSEG 5'h0B
`define OTD_OP_FPL_GSEG 5'h0C
`define OTD_OP_FPL_SSEG 5'h0D
`define OTD_OP_CARRY_CLR 5'h0E
`define OTD_OP_DIR_CLR 5'h0F
`define OTD_OP_IRQ_CLR 5'h10
`define OTD_OP_TS_CLR 5'h11
`define OTD_OP_CARRY_INV 5'h12
`define OTD_OP_UNKNOWN 5'h1F
// Clock counts.
`define OTD_CLK_POP_SEG_REAL 6'h07
`define OTD_CLK_POP_SEG_PROT 6'h15
`define OTD_CLK_POP_REG 6'h04
`define OTD_CLK_SWAP_REG 6'h03
`define OTD_CLK_SWAP_MEM 6'h05
`define OTD_CLK_SWAP_ACC 6'h03
`define OTD_CLK_IN_REAL 6'h0C
`define OTD_CLK_IN_PRIV 6'h06
`define OTD_CLK_IN_UNPRIV 6'h1A
`define OTD_CLK_EA_LOAD 6'h02
`define OTD_CLK_FPL_REAL 6'h07
`define OTD_CLK_FPL_PROT 6'h16
`define OTD_CLK_FPL_XPROT 6'h19
`define OTD_CLK_FLAG 6'h02
`define OTD_CLK_IRQ_CLR 6'h08
`define OTD_CLK_TS_CLR 6'h06
`define OTD_CLK_TWO_REG_EA 6'h01
`define OTD_GP_VECTOR 8'h0D
`endif

// file: core/otd_modrm_split.v
// Splits a mod reg r/m byte and detects a two-register effective address.
`timescale 1ns/1ps
`default_nettype none
`include "otd_consts.vh"
module otd_modrm_split (
  // Mod reg r/m byte, address size and scaled-index byte.
  input wire [7:0] modrm,
  input wire addr32,
  input wire [7:0] sib,
  // Decoded fields.
  output wire is_reg,
  output wire [2:0] reg_field,
  output wire two_reg_ea
);
  wire [1:0] mode_bits;
  wire [2:0] rm;
  assign mode_bits = modrm[7:6];
  assign rm = modrm[2:0];
  assign reg_field = modrm[5:3];
  assign is_reg = (mode_bits == `OTD_MOD_REG);
  // In 16-bit addressing r/m 0 to 3 combine a base and an index register.
  // In 32-bit addressing a scaled-index byte with index not 4 and a real base does so.
  assign two_reg_ea = !is_reg && (addr32 ?
    ((rm == 3'h4) && (sib[5:3] != 3'h4) && !((sib[2:0] == 3'h5) && (mode_bits == 2'h0))) :
    (rm[2] == 1'b0));
endmodule // otd_modrm_split
`default_nettype wire

// file: core/otd_port_check.v
// Decides the privilege outcome and timing of a fixed-port input.
`timescale 1ns/1ps
`default_nettype none
`include "otd_consts.vh"
module otd_port_check (
  // Mode and privilege state.
  input wire [1:0] mode,
  input wire [1:0] current_privilege_level,
  input wire [1:0] io_privilege_level,
  input wire port_permitted,
  // Outcome.
  output reg fault,
  output reg [5:0] clocks
);
  always @*
  begin
    fault = 1'b0;
    clocks = `OTD_CLK_IN_REAL;
    case (mode)
      `OTD_MODE_REAL: clocks = `OTD_CLK_IN_REAL;
      `OTD_MODE_PROT: clocks = (current_privilege_level <= io_privilege_level) ?
        `OTD_CLK_IN_PRIV : `OTD_CLK_IN_UNPRIV;
      `OTD_MODE_V86:
      begin
        clocks = `OTD_CLK_IN_UNPRIV;
        fault = !port_permitted;
      end
      default: clocks = `OTD_CLK_IN_REAL;
    endcase
  end
endmodule // otd_port_check
`default_nettype wire

// file: bench/otd_decoder_properties.sv
// Port-level timing and decode checks for the opcode timing decoder.
`timescale 1ns/1ps
`default_nettype none
`include "otd_consts.vh"
module otd_decoder_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Byte handshake and mode.
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire logic [1:0] mode,
  // Decode result.
  input wire logic done,
  input wire logic [4:0] op_class,
  input wire logic [5:0] clocks,
  input wire logic mem_operand,
  input wire logic [7:0] fault_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_ready_up; !srst |=> byte_ready; endproperty
  a_ready_up: assert property (p_ready_up) else $error("byte_ready low outside reset");
  property p_done_cause; done |-> $past(byte_valid && byte_ready); endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without a byte taken");
  property p_hold; !done && !$past(srst) |-> $stable(clocks) && $stable(op_class); endproperty
  a_hold: assert property (p_hold) else $error("result changed between done pulses");
  property p_flag2;
    done && (op_class == `OTD_OP_CARRY_CLR || op_class == `OTD_OP_DIR_CLR || op_class == `OTD_OP_CARRY_INV)
      |-> clocks == 6'h02;
  endproperty
  a_flag2: assert property (p_flag2) else $error("flag operation count wrong");
  property p_irq; done && op_class == `OTD_OP_IRQ_CLR |-> clocks == 6'h08; endproperty
  a_irq: assert property (p_irq) else $error("interrupt clear count wrong");
  property p_ts; done && op_class == `OTD_OP_TS_CLR |-> clocks == 6'h06; endproperty
  a_ts: assert property (p_ts) else $error("task-switched clear count wrong");
  property p_pop_reg; done && op_class == `OTD_OP_POP_REG |-> clocks == 6'h04; endproperty
  a_pop_reg: assert property (p_pop_reg) else $error("register pop count wrong");
  property p_swap;
    done && (op_class == `OTD_OP_SWAP_ACC || (op_class == `OTD_OP_SWAP_RM && !mem_operand)) |-> clocks == 6'h03;
  endproperty
  a_swap: assert property (p_swap) else $error("register swap count wrong");
  property p_fault; done |-> (fault_vector == 8'h0D) == (op_class == `OTD_OP_GP_FAULT); endproperty
  a_fault: assert property (p_fault) else $error("fault vector disagrees with class");
  property p_in_real; done && op_class == `OTD_OP_IN_FIXED && $past(mode) == 2'h0 |-> clocks == 6'h0C; endproperty
  a_in_real: assert property (p_in_real) else $error("real mode port input count wrong");
  property p_pop_prot;
    done && (op_class == `OTD_OP_POP_SEG || op_class == `OTD_OP_POP_XSEG) && $past(mode) == 2'h1
      |-> clocks == 6'h15;
  endproperty
  a_pop_prot: assert property (p_pop_prot) else $error("protected segment pop count wrong");
  c_fault: cover property (done && op_class == `OTD_OP_GP_FAULT);
  c_back_to_back: cover property (done ##1 done);
  c_swap_mem: cover property (done && op_class == `OTD_OP_SWAP_RM && mem_operand);
endmodule // otd_decoder_properties

bind otd_decoder otd_decoder_properties u_otd_decoder_properties (.clk(clk), .srst(srst),
  .byte_valid(byte_valid), .byte_ready(byte_ready), .mode(mode), .done(done), .op_class(op_class),
  .clocks(clocks), .mem_operand(mem_operand), .fault_vector(fault_vector));
`default_nettype wire

// file: bench/otd_prefetch_model.sv
// Behavioural prefetch queue feeding opcode bytes to the decoder.
`timescale 1ns/1ps
`default_nettype none
module otd_prefetch_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Pacing and handshake.
  input wire logic [1:0] stall,
  input wire logic byte_ready,
  // Byte stream.
  output logic byte_valid = 1'b0,
  output logic [7:0] byte_data = 8'h00
);
  logic [7:0] q[$];
  logic taken = 1'b0;
  int idle = 0;
  // The handshake is judged at the rising edge; the stream moves at the falling edge.
  always @(posedge clk)
  begin
    taken <= byte_valid && byte_ready && !srst;
    if (srst)
      q.delete();
  end
  // Idle data toggles so a stale byte is never mistaken for a fresh one.
  always @(negedge clk)
  begin
    if (taken)
    begin
      void'(q.pop_front());
      idle = stall;
    end
    if (!srst && q.size() > 0 && idle == 0)
    begin
      byte_valid <= 1'b1;
      byte_data <= q[0];
    end
    else
    begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
      if (idle > 0)
        idle = idle - 1;
    end
  end
endmodule // otd_prefetch_model
`default_nettype wire

// file: bench/opcode_timing_decoder_subset_test.sv
// Self-checking bench for the opcode timing decoder.
`timescale 1ns/1ps
`default_nettype none
`include "otd_consts.vh"
module opcode_timing_decoder_subset_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic byte_valid, byte_ready, done, wide, mem_operand;
  logic addr32 = 1'b0;
  logic port_permitted = 1'b1;
  logic [7:0] byte_data, port_num, fault_vector;
  logic [1:0] mode = 2'h0;
  logic [1:0] priv = 2'h0;
  logic [1:0] io_priv = 2'h0;
  logic [1:0] stall = 2'h0;
  logic [1:0] seg_sel;
  logic [4:0] op_class;
  logic [5:0] clocks;
  logic [2:0] reg_sel;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  otd_prefetch_model u_otd_prefetch_model (.clk(clk), .srst(srst), .stall(stall), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));
  otd_decoder u_otd_decoder (.clk(clk), .srst(srst), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .mode(mode), .current_privilege_level(priv), .io_privilege_level(io_priv),
    .port_permitted(port_permitted), .addr32(addr32), .done(done), .op_class(op_class), .clocks(clocks),
    .reg_sel(reg_sel), .seg_sel(seg_sel), .wide(wide), .mem_operand(mem_operand), .port_num(port_num),
    .fault_vector(fault_vector));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Queues one instruction, waits for its done pulse and judges class and count.
  task automatic step(input logic [7:0] b[$], input logic [4:0] op, input logic [5:0] ck);
    foreach (b[i])
      u_otd_prefetch_model.q.push_back(b[i]);
    @(negedge clk);
    for (int k = 0; k < 40 && done !== 1'b1; k++)
      @(negedge clk);
    check(done, 1'b1);
    check(op_class, op);
    check(clocks, ck);
  endtask

  task automatic t_flags();
    mode = `OTD_MODE_PROT;
    step({8'hF8}, `OTD_OP_CARRY_CLR, 6'h02);
    step({8'hFC}, `OTD_OP_DIR_CLR, 6'h02);
    step({8'hFA}, `OTD_OP_IRQ_CLR, 6'h08);
    step({8'h0F, 8'h06}, `OTD_OP_TS_CLR, 6'h06);
    step({8'hF5}, `OTD_OP_CARRY_INV, 6'h02);
    step({8'h0F, 8'hFF}, `OTD_OP_UNKNOWN, 6'h00);
  endtask

  task automatic t_pops();
    mode = `OTD_MODE_REAL;
    step({8'h07}, `OTD_OP_POP_SEG, 6'h07);
    check(seg_sel, 2'h0);
    step({8'h0F, 8'hA9}, `OTD_OP_POP_XSEG, 6'h07);
    check(seg_sel, 2'h3);
    mode = `OTD_MODE_PROT;
    step({8'h1F}, `OTD_OP_POP_SEG, 6'h15);
    check(seg_sel, 2'h3);
    step({8'h0F, 8'hA1}, `OTD_OP_POP_XSEG, 6'h15);
    step({8'h5D}, `OTD_OP_POP_REG, 6'h04);
    check(reg_sel, 3'h5);
  endtask

  task automatic t_swap_ea();
    stall = 2'h3;
    step({8'h87, 8'hC1}, `OTD_OP_SWAP_RM, 6'h03);
    check(mem_operand, 1'b0);
    check(wide, 1'b1);
    step({8'h86, 8'h44}, `OTD_OP_SWAP_RM, 6'h05);
    check(wide, 1'b0);
    step({8'h87, 8'h00}, `OTD_OP_SWAP_RM, 6'h06);
    addr32 = 1'b1;
    step({8'h87, 8'h04, 8'h18}, `OTD_OP_SWAP_RM, 6'h06);
    step({8'h87, 8'h04, 8'h20}, `OTD_OP_SWAP_RM, 6'h05);
    addr32 = 1'b0;
    step({8'h93}, `OTD_OP_SWAP_ACC, 6'h03);
    check(reg_sel, 3'h3);
    step({8'h8D, 8'h46}, `OTD_OP_EA_LOAD, 6'h02);
    step({8'h8D, 8'h02}, `OTD_OP_EA_LOAD, 6'h03);
    stall = 2'h0;
  endtask

  task automatic t_far_ptr();
    for (int m = 0; m < 2; m++)
    begin
      mode = m[1:0];
      step({8'hC5, 8'h07}, `OTD_OP_FPL_DSEG, (m != 0) ? 6'h16 : 6'h07);
      step({8'hC4, 8'h07}, `OTD_OP_FPL_ESEG, (m != 0) ? 6'h16 : 6'h07);
      step({8'h0F, 8'hB4, 8'h07}, `OTD_OP_FPL_FSEG, (m != 0) ? 6'h19 : 6'h07);
      step({8'h0F, 8'hB5, 8'h07}, `OTD_OP_FPL_GSEG, (m != 0) ? 6'h19 : 6'h07);
      step({8'h0F, 8'hB2, 8'h07}, `OTD_OP_FPL_SSEG, (m != 0) ? 6'h16 : 6'h07);
    end
  endtask

  task automatic t_port();
    mode = `OTD_MODE_REAL;
    step({8'hE4, 8'h5A}, `OTD_OP_IN_FIXED, 6'h0C);
    check(port_num, 8'h5A);
    mode = `OTD_MODE_PROT;
    priv = 2'h2;
    io_priv = 2'h2;
    step({8'hE5, 8'hA5}, `OTD_OP_IN_FIXED, 6'h06);
    check(wide, 1'b1);
    priv = 2'h3;
    step({8'hE4, 8'h3C}, `OTD_OP_IN_FIXED, 6'h1A);
    mode = `OTD_MODE_V86;
    step({8'hE4, 8'h3C}, `OTD_OP_IN_FIXED, 6'h1A);
    check(fault_vector, 8'h00);
    port_permitted = 1'b0;
    step({8'hE4, 8'h3C}, `OTD_OP_GP_FAULT, 6'h1A);
    check(fault_vector, 8'h0D);
    port_permitted = 1'b1;
  endtask

  // Back-to-back bytes, then a reset that lands after an escape byte.
  task automatic t_stream_reset();
    step({8'hF8, 8'hFC}, `OTD_OP_CARRY_CLR, 6'h02);
    @(negedge clk);
    check(done, 1'b1);
    check(op_class, `OTD_OP_DIR_CLR);
    u_otd_prefetch_model.q.push_back(8'h0F);
    repeat (4) @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    check(op_class, 8'h00);
    check(byte_ready, 1'b0);
    srst = 1'b0;
    step({8'hF8}, `OTD_OP_CARRY_CLR, 6'h02);
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check(byte_ready, 1'b1);
    t_flags();
    t_pops();
    t_swap_ea();
    t_far_ptr();
    t_port();
    t_stream_reset();
    end_sim();
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      bad_count++;
      end_sim();
    end
  end
endmodule // opcode_timing_decoder_subset_test
`default_nettype wire
